// ### hdl/tcc_timer16_cc.sv
// Input capture and output compare logic of a 16-bit timer, APB register slave
// Contract
// - Comparator select bit routes comparator output to capture instead of pin.
// - Changing capture source may capture; software clears capture flag afterwards.
// - Both sources synchronised like timer clock pin; filter adds four cycles.
// - Filter and edge detector active except in capture-as-TOP modes; code keeps both running there and masks only the capture event.
// - Software driving capture pin through its port output triggers captures.
// - Filter output changes only after four equal consecutive samples.
// - Filter enable bit in control; filter runs on system clock.
// - Every capture overwrites capture register, read or not.
// - Comparators match counter; flag set on following timer clock cycle.
// - Set compare flag with enable requests interrupt; ack or write-one clears.
// - Compare channel A value usable as counter TOP.
// - PWM modes double buffer compare, load at TOP or BOTTOM.
// - CPU reaches buffer when buffering active, else compare register.
// - Compare high byte read directly, not through shared latch.
// - High byte into latch first; low write loads all 16 bits at once.
// - Force strobe updates output state in non-PWM modes, sets no flag.
// - Counter write blocks any match in the next timer clock cycle.
// - Counter written equal to variable TOP loses TOP match.
// - Output state kept when waveform mode changes.
// - Output action bits not buffered; take effect immediately.
// - Capture copies counter and sets capture flag same cycle.
// - Capture low read copies high byte into latch; high read returns it.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "tcc_defs.svh"

module tcc_timer16_cc (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        CAPTURE_PIN,
  input  wire logic        COMPARATOR_OUTPUT,
  input  wire logic [15:0] COUNTER_VALUE,
  input  wire logic        TIMER_TICK,
  input  wire logic        COUNTER_TOP,
  input  wire logic        COUNTER_BOTTOM,
  input  wire logic        COUNTER_WRITE,
  input  wire logic        IRQ_ACK_CAPTURE,
  input  wire logic        IRQ_ACK_CMP_A,
  input  wire logic        IRQ_ACK_CMP_B,
  output logic             IRQ_CAPTURE,
  output logic             IRQ_CMP_A,
  output logic             IRQ_CMP_B,
  output logic             MATCH_A,
  output logic             MATCH_B,
  output logic      [15:0] CMP_TOP_A,
  output logic             OC_A,
  output logic             OC_B
);

  // ----------------------------------------
  // Mode decoding
  // ----------------------------------------
  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD);
  endfunction : is_pwm

  function automatic logic icr_top(input logic [3:0] m);
    icr_top = (m == 4'h8 || m == 4'hA || m == 4'hC || m == 4'hE);
  endfunction : icr_top

  function automatic logic upd_bottom(input logic [3:0] m);
    upd_bottom = (m == 4'h8 || m == 4'h9);
  endfunction : upd_bottom

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `TCC_A_FORCE);
  endfunction : mapped

  function automatic logic oc_act(input tcc_pkg::tcc_act_type act,
                                  input logic cur);
    unique case (act)
      2'h1:    oc_act = ~cur;
      2'h2:    oc_act = 1'b0;
      2'h3:    oc_act = 1'b1;
      default: oc_act = cur;
    endcase
  endfunction : oc_act

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  tcc_pkg::tcc_apb_type  state;
  logic [`TCC_C_W-1:0]   ctrl;
  logic [7:0]            temp;
  tcc_pkg::tcc_word_type capture;
  logic                  cflag;
  logic                  s1;
  logic                  s2;
  logic [`TCC_FILT_LEN-2:0] hist;
  logic                  filt;
  logic                  prev;
  logic                  blk;
  tcc_pkg::tcc_word_type cmp [2];
  tcc_pkg::tcc_word_type bfr [2];
  logic [1:0]            flag;
  logic [1:0]            pend;
  logic [1:0]            oc;
  logic [1:0]            mpulse;
  logic [1:0]            irq_c;
  logic [1:0]            raw;
  logic [1:0]            frc;

  wire logic [3:0] mode     = ctrl[`TCC_C_WGM +: 4];
  wire logic       pwm      = is_pwm(mode);
  wire logic       acc      = CE && PSEL && PENABLE && PREADY;
  wire logic       wr       = acc && PWRITE;
  wire logic       rd       = acc && !PWRITE;
  wire logic       src      = ctrl[`TCC_C_ACMP] ? COMPARATOR_OUTPUT
                                                : CAPTURE_PIN;
  wire logic       ein      = ctrl[`TCC_C_FILT] ? filt : s2;
  wire logic       rise     = ein && !prev;
  wire logic       fall     = !ein && prev;
  wire logic       cap_evt  = CE && !icr_top(mode)
                              && (ctrl[`TCC_C_EDGE] ? rise : fall);
  wire logic       upd_evt  = TIMER_TICK && (upd_bottom(mode) ? COUNTER_BOTTOM
                                                               : COUNTER_TOP);
  wire logic       cap_rdlo = rd && PADDR == `TCC_A_CAP_LO;
  wire logic       st_wr    = wr && PADDR == `TCC_A_STATUS;

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state   <= tcc_pkg::TCC_IDLE;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else if (CE) begin
      unique case (state)
        tcc_pkg::TCC_IDLE: begin
          if (PSEL && PENABLE) begin
            state   <= tcc_pkg::TCC_DONE;
            PREADY  <= 1'b1;
            PSLVERR <= !mapped(PADDR);
            PRDATA  <= 32'h00000000;
            if (!PWRITE) begin
              unique case (PADDR)
                `TCC_A_CTRL:    PRDATA <= {18'h0, ctrl};
                `TCC_A_STATUS:  PRDATA <= {27'h0, oc, flag, cflag};
                `TCC_A_CAP_LO:  PRDATA <= {24'h000000, capture[7:0]};
                `TCC_A_CAP_HI:  PRDATA <= {24'h000000, temp};
                `TCC_A_CMPA_LO: PRDATA <= {24'h000000, pwm ? bfr[0][7:0]
                                                          : cmp[0][7:0]};
                `TCC_A_CMPA_HI: PRDATA <= {24'h000000, pwm ? bfr[0][15:8]
                                                          : cmp[0][15:8]};
                `TCC_A_CMPB_LO: PRDATA <= {24'h000000, pwm ? bfr[1][7:0]
                                                          : cmp[1][7:0]};
                `TCC_A_CMPB_HI: PRDATA <= {24'h000000, pwm ? bfr[1][15:8]
                                                          : cmp[1][15:8]};
                default:        PRDATA <= 32'h00000000;
              endcase
            end
          end
        end
        tcc_pkg::TCC_DONE: begin
          state   <= tcc_pkg::TCC_IDLE;
          PREADY  <= 1'b0;
          PSLVERR <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Control register and shared high-byte latch
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= `TCC_CTRL_RST;
    end else if (wr && PADDR == `TCC_A_CTRL) begin
      ctrl <= PWDATA[`TCC_C_W-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      temp <= 8'h00;
    end else if (cap_rdlo) begin
      temp <= capture[15:8];
    end else if (wr && (PADDR == `TCC_A_CAP_HI || PADDR == `TCC_A_CMPA_HI
                        || PADDR == `TCC_A_CMPB_HI)) begin
      temp <= PWDATA[7:0];
    end
  end

  // ----------------------------------------
  // Capture input: synchroniser, filter, edge detector
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else if (CE) begin
      s1 <= src;
      s2 <= s1;
    end
  end

  // Filter samples every system clock, prescaler plays no part
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hist <= 3'h0;
      filt <= 1'b0;
    end else if (CE) begin
      hist <= {hist[`TCC_FILT_LEN-3:0], s2};
      if ({hist, s2} == 4'hF) begin
        filt <= 1'b1;
      end else if ({hist, s2} == 4'h0) begin
        filt <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prev <= 1'b0;
    end else if (CE) begin
      prev <= ein;
    end
  end

  // Each event overwrites the value and sets the flag together
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      capture <= 16'h0000;
    end else if (cap_evt) begin
      capture <= COUNTER_VALUE;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cflag       <= 1'b0;
      IRQ_CAPTURE <= 1'b0;
    end else if (CE) begin
      cflag <= cap_evt
               || (cflag && !IRQ_ACK_CAPTURE
                   && !(st_wr && PWDATA[`TCC_S_CAP]));
      IRQ_CAPTURE <= cflag && ctrl[`TCC_C_IEC];
    end
  end

  // ----------------------------------------
  // Compare match blocking after a counter write
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      blk <= 1'b0;
    end else if (CE) begin
      if (COUNTER_WRITE) begin
        blk <= 1'b1;
      end else if (TIMER_TICK) begin
        blk <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Compare channels
  // ----------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
    localparam logic [7:0] ALO = ch ? `TCC_A_CMPB_LO : `TCC_A_CMPA_LO;
    wire tcc_pkg::tcc_act_type act = ch ? ctrl[`TCC_C_ACTB +: 2]
                                        : ctrl[`TCC_C_ACTA +: 2];
    wire logic ie = ch ? ctrl[`TCC_C_IEB] : ctrl[`TCC_C_IEA];
    wire logic ack = ch ? IRQ_ACK_CMP_B : IRQ_ACK_CMP_A;
    wire logic wlo = wr && PADDR == ALO;

    assign raw[ch] = CE && TIMER_TICK && !blk
                     && COUNTER_VALUE == cmp[ch];
    assign frc[ch] = wr && PADDR == `TCC_A_FORCE && PWDATA[ch];

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        cmp[ch] <= 16'h0000;
        bfr[ch] <= 16'h0000;
      end else if (CE) begin
        if (wlo) begin
          bfr[ch] <= {temp, PWDATA[7:0]};
          if (!pwm) begin
            cmp[ch] <= {temp, PWDATA[7:0]};
          end
        end else if (pwm && upd_evt) begin
          cmp[ch] <= bfr[ch];
        end
      end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        pend[ch]   <= 1'b0;
        mpulse[ch] <= 1'b0;
      end else if (CE) begin
        mpulse[ch] <= raw[ch];
        if (TIMER_TICK) begin
          pend[ch] <= raw[ch];
        end
      end
    end

    // Flag lands on the timer tick after the match, set beats clear
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        flag[ch]  <= 1'b0;
        irq_c[ch] <= 1'b0;
      end else if (CE) begin
        flag[ch] <= (TIMER_TICK && pend[ch])
                    || (flag[ch] && !ack
                        && !(st_wr && PWDATA[`TCC_S_CMP + ch]));
        irq_c[ch] <= flag[ch] && ie;
      end
    end

    // Output state survives mode changes; only reset, the clear action or the toggle action drives it low
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        oc[ch] <= 1'b0;
      end else if (CE && !pwm) begin
        if (frc[ch] || (TIMER_TICK && pend[ch])) begin
          oc[ch] <= oc_act(act, oc[ch]);
        end
      end
    end
  end

  assign IRQ_CMP_A = irq_c[0];
  assign IRQ_CMP_B = irq_c[1];
  assign MATCH_A   = mpulse[0];
  assign MATCH_B   = mpulse[1];
  assign CMP_TOP_A = cmp[0];
  assign OC_A      = oc[0];
  assign OC_B      = oc[1];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  src_select_a: assert property (
    CE && ctrl[`TCC_C_ACMP] |=> s1 == $past(COMPARATOR_OUTPUT))
    else $error("capture source not comparator");
  filter_four_a: assert property (
    !$stable(filt) |-> $past({hist, s2}) == 4'hF || $past({hist, s2}) == 4'h0)
    else $error("filter changed without four equal samples");
  icr_top_off_a: assert property (
    CE && icr_top(mode) |=> capture == $past(capture))
    else $error("capture in capture-as-top mode");
  capture_stamp_a: assert property (
    cap_evt |=> cflag && capture == $past(COUNTER_VALUE))
    else $error("capture value or flag wrong");
  cap_latch_a: assert property (
    cap_rdlo |=> temp == $past(capture[15:8]))
    else $error("latch not loaded on capture low read");
  cmp_flag_a: assert property (
    CE && TIMER_TICK && pend[0] |=> flag[0])
    else $error("compare flag not set after match");
  cmp_irq_a: assert property (
    CE && flag[0] && ctrl[`TCC_C_IEA] |=> IRQ_CMP_A)
    else $error("compare irq missing");
  write_block_a: assert property (
    CE && blk && TIMER_TICK |=> !MATCH_A && !MATCH_B)
    else $error("match not blocked after counter write");
  cmp_load_a: assert property (
    CE && !pwm && wr && PADDR == `TCC_A_CMPA_LO
    |=> cmp[0] == {$past(temp), $past(PWDATA[7:0])})
    else $error("compare not loaded in one cycle");
  buf_hold_a: assert property (
    CE && pwm && !upd_evt |=> cmp[0] == $past(cmp[0]))
    else $error("buffered compare changed off update");
  force_noflag_a: assert property (
    frc[0] && !pwm && !pend[0] && !flag[0] && !TIMER_TICK
    && ctrl[`TCC_C_ACTA +: 2] == 2'h1
    |=> oc[0] != $past(oc[0]) && !flag[0])
    else $error("force did not toggle or set flag");
  cap_cov: cover property (cap_evt ##[1:20] cap_rdlo);
  force_cov: cover property (frc[1] && !pwm);
  upd_cov: cover property (pwm && upd_evt);

endmodule : tcc_timer16_cc

// ### hdl/tcc_defs.svh
// Register offsets, field positions and reset values of the capture/compare block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCC_A_CTRL    8'h00
`define TCC_A_STATUS  8'h04
`define TCC_A_CAP_LO  8'h08
`define TCC_A_CAP_HI  8'h0C
`define TCC_A_CMPA_LO 8'h10
`define TCC_A_CMPA_HI 8'h14
`define TCC_A_CMPB_LO 8'h18
`define TCC_A_CMPB_HI 8'h1C
`define TCC_A_FORCE   8'h20

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TCC_C_FILT  0
`define TCC_C_EDGE  1
`define TCC_C_ACMP  2
`define TCC_C_WGM   3
`define TCC_C_ACTA  7
`define TCC_C_ACTB  9
`define TCC_C_IEA   11
`define TCC_C_IEB   12
`define TCC_C_IEC   13
`define TCC_C_W     14
`define TCC_CTRL_RST 14'h0000

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define TCC_S_CAP  0
`define TCC_S_CMP  1
`define TCC_S_OC   3

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define TCC_FILT_LEN 4

`endif

// ### hdl/tcc_pkg.sv
// Types shared by the capture/compare block
package tcc_pkg;

  typedef enum logic [1:0] {
    TCC_IDLE = 2'b01,
    TCC_DONE = 2'b10
  } tcc_apb_type;

  typedef logic [15:0] tcc_word_type;
  typedef logic [1:0]  tcc_act_type;

endpackage : tcc_pkg

// ### verification/tcc_event_src.sv
// Far-side model: capture pin and comparator output driving the block
`timescale 1ns/1ps

module tcc_event_src (
  input  wire logic clk,
  output logic      pin,
  output logic      cmp
);

  initial begin
    pin = 1'b0;
    cmp = 1'b0;
  end

  // ----------------------------------------
  // Level drivers, called just after a clock edge
  // ----------------------------------------
  // Pin level stands for the port output driven by software
  task set_lines(input logic p, input logic c);
    pin <= p;
    cmp <= c;
  endtask : set_lines

  // Pulse of n clocks on the pin; below four clocks it is too short to pass the filter
  task glitch_pin(input int n);
    pin <= ~pin;
    repeat (n) @(posedge clk);
    pin <= ~pin;
  endtask : glitch_pin

endmodule : tcc_event_src

// ### verification/tcc_timer16_cc_bench.sv
// Self-checking bench of the capture/compare block
`timescale 1ns/1ps
`include "tcc_defs.svh"

module tcc_timer16_cc_bench;

  logic        clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        rerr, tick, top, bottom, cwr, ack_c, ack_a, ack_b;
  logic        irq_c, irq_a, irq_b, match_a, match_b, oc_a, oc_b, pin, cmp;
  logic [15:0] cnt, top_a;
  int          errors, check_count;

  tcc_timer16_cc DUT (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CAPTURE_PIN(pin), .COMPARATOR_OUTPUT(cmp),
    .COUNTER_VALUE(cnt), .TIMER_TICK(tick), .COUNTER_TOP(top),
    .COUNTER_BOTTOM(bottom), .COUNTER_WRITE(cwr), .IRQ_ACK_CAPTURE(ack_c),
    .IRQ_ACK_CMP_A(ack_a), .IRQ_ACK_CMP_B(ack_b), .IRQ_CAPTURE(irq_c),
    .IRQ_CMP_A(irq_a), .IRQ_CMP_B(irq_b), .MATCH_A(match_a), .MATCH_B(match_b),
    .CMP_TOP_A(top_a), .OC_A(oc_a), .OC_B(oc_b)
  );

  tcc_event_src src (.clk(clk), .pin(pin), .cmp(cmp));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr_reg

  task rd_reg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd_reg

  task edge_at(input logic [15:0] v, input logic p, input logic c);
    @(posedge clk);
    cnt <= v;
    src.set_lines(p, c);
    repeat (10) @(posedge clk);
  endtask : edge_at

  task pulse_tick(input logic [15:0] v, input logic t);
    @(posedge clk);
    cnt <= v;
    tick <= 1'b1;
    top <= t;
    @(posedge clk);
    tick <= 1'b0;
    top <= 1'b0;
    @(negedge clk);
  endtask : pulse_tick

  task stamp;
    int i;
    edge_at(16'h0000, 1'b0, 1'b0);
    wr_reg(`TCC_A_STATUS, 32'h1);
    @(posedge clk);
    cnt <= 16'h0000;
    src.set_lines(1'b1, 1'b0);
    for (i = 1; i < 20; i++) begin
      @(posedge clk);
      cnt <= i[15:0];
    end
    rd_reg(`TCC_A_CAP_LO);
  endtask : stamp

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    int a;
    for (a = 0; a < 9; a++) begin
      rd_reg(8'(a * 4));
      chk("reset value", 32'h0, rdat);
      chk("mapped err", 32'h0, rerr);
    end
    wr_reg(8'h24, 32'hFFFFFFFF);
    chk("unmapped wr err", 32'h1, rerr);
    rd_reg(8'h24);
    chk("unmapped rd err", 32'h1, rerr);
    chk("unmapped rd data", 32'h0, rdat);
    $display("Test reset done");
  endtask : t_reset

  task t_capture;
    wr_reg(`TCC_A_CTRL, (32'h1 << `TCC_C_EDGE) | (32'h1 << `TCC_C_IEC));
    wr_reg(`TCC_A_STATUS, 32'h1);
    edge_at(16'h5555, 1'b1, 1'b0);
    rd_reg(`TCC_A_STATUS);
    chk("cap flag", 32'h1, rdat[`TCC_S_CAP]);
    chk("irq_c", 32'h1, irq_c);
    @(posedge clk);
    ack_c <= 1'b1;
    @(posedge clk);
    ack_c <= 1'b0;
    rd_reg(`TCC_A_STATUS);
    chk("cap flag ack", 32'h0, rdat[`TCC_S_CAP]);
    edge_at(16'h6666, 1'b0, 1'b0);
    rd_reg(`TCC_A_STATUS);
    chk("falling ignored", 32'h0, rdat[`TCC_S_CAP]);
    edge_at(16'hABCD, 1'b1, 1'b0);
    edge_at(16'h0000, 1'b1, 1'b0);
    rd_reg(`TCC_A_CAP_LO);
    chk("cap lo", 32'hCD, rdat);
    rd_reg(`TCC_A_CAP_HI);
    chk("cap hi", 32'hAB, rdat);
    wr_reg(`TCC_A_STATUS, 32'h1);
    rd_reg(`TCC_A_STATUS);
    chk("cap flag w1c", 32'h0, rdat[`TCC_S_CAP]);
    $display("Test capture done");
  endtask : t_capture

  task t_source;
    wr_reg(`TCC_A_CTRL, (32'h1 << `TCC_C_EDGE) | (32'h1 << `TCC_C_ACMP));
    wr_reg(`TCC_A_STATUS, 32'h1);
    edge_at(16'h1111, 1'b0, 1'b0);
    edge_at(16'h2222, 1'b1, 1'b0);
    rd_reg(`TCC_A_STATUS);
    chk("pin ignored", 32'h0, rdat[`TCC_S_CAP]);
    edge_at(16'h3333, 1'b1, 1'b1);
    rd_reg(`TCC_A_CAP_LO);
    chk("cmp capture", 32'h33, rdat);
    wr_reg(`TCC_A_CTRL, (32'h1 << `TCC_C_EDGE) | (32'h1 << `TCC_C_ACMP) | (32'hC << `TCC_C_WGM));
    wr_reg(`TCC_A_STATUS, 32'h1);
    edge_at(16'h4444, 1'b1, 1'b0);
    edge_at(16'h4444, 1'b1, 1'b1);
    rd_reg(`TCC_A_STATUS);
    chk("capture off", 32'h0, rdat[`TCC_S_CAP]);
    $display("Test source done");
  endtask : t_source

  task t_filter;
    logic [31:0] base;
    wr_reg(`TCC_A_CTRL, 32'h1 << `TCC_C_EDGE);
    stamp();
    base = rdat;
    wr_reg(`TCC_A_CTRL, (32'h1 << `TCC_C_EDGE) | (32'h1 << `TCC_C_FILT));
    stamp();
    chk("filter delay", base + 32'h4, rdat);
    edge_at(16'h0000, 1'b0, 1'b0);
    wr_reg(`TCC_A_STATUS, 32'h1);
    @(posedge clk);
    src.glitch_pin(3);
    repeat (10) @(posedge clk);
    rd_reg(`TCC_A_STATUS);
    chk("glitch rejected", 32'h0, rdat[`TCC_S_CAP]);
    edge_at(16'h0000, 1'b1, 1'b0);
    rd_reg(`TCC_A_STATUS);
    chk("steady accepted", 32'h1, rdat[`TCC_S_CAP]);
    $display("Test filter done");
  endtask : t_filter

  task t_compare;
    wr_reg(`TCC_A_CTRL, (32'h1 << `TCC_C_IEA) | (32'h1 << `TCC_C_IEB));
    wr_reg(`TCC_A_CMPA_HI, 32'h12);
    wr_reg(`TCC_A_CMPA_LO, 32'h34);
    wr_reg(`TCC_A_CMPB_LO, 32'h34);
    @(negedge clk);
    chk("top_a direct", 32'h1234, top_a);
    pulse_tick(16'h1234, 1'b0);
    chk("match_a", 32'h1, match_a);
    chk("match_b", 32'h1, match_b);
    @(negedge clk);
    chk("match_a pulse", 32'h0, match_a);
    rd_reg(`TCC_A_STATUS);
    chk("flag a early", 32'h0, rdat[`TCC_S_CMP]);
    pulse_tick(16'h0001, 1'b0);
    repeat (2) @(negedge clk);
    chk("irq_a", 32'h1, irq_a);
    chk("irq_b", 32'h1, irq_b);
    rd_reg(`TCC_A_STATUS);
    chk("flag a", 32'h1, rdat[`TCC_S_CMP]);
    @(posedge clk);
    ack_a <= 1'b1;
    @(posedge clk);
    ack_a <= 1'b0;
    rd_reg(`TCC_A_STATUS);
    chk("flag a ack", 32'h0, rdat[`TCC_S_CMP]);
    @(posedge clk);
    cwr <= 1'b1;
    @(posedge clk);
    cwr <= 1'b0;
    pulse_tick(16'h1234, 1'b0);
    chk("match blocked", 32'h0, match_a);
    $display("Test compare done");
  endtask : t_compare

  task t_force;
    logic e;
    int a;
    e = 1'b0;
    for (a = 0; a < 4; a++) begin
      wr_reg(`TCC_A_CTRL, (a << `TCC_C_ACTA) | (a << `TCC_C_ACTB));
      wr_reg(`TCC_A_FORCE, 32'h3);
      e = (a == 1) ? ~e : (a == 0) ? e : (a == 3);
      repeat (2) @(negedge clk);
      chk("oc_a forced", e, oc_a);
      chk("oc_b forced", e, oc_b);
    end
    rd_reg(`TCC_A_STATUS);
    chk("force no flag", 32'h0, rdat[`TCC_S_CMP]);
    chk("oc status", 32'h1, rdat[`TCC_S_OC]);
    chk("oc b status", 32'h1, rdat[`TCC_S_OC + 1]);
    wr_reg(`TCC_A_CTRL, (32'hF << `TCC_C_WGM) | (32'h3 << `TCC_C_ACTA));
    @(negedge clk);
    chk("oc kept", 32'h1, oc_a);
    $display("Test force done");
  endtask : t_force

  task t_buffer;
    wr_reg(`TCC_A_CMPA_HI, 32'h56);
    wr_reg(`TCC_A_CMPA_LO, 32'h78);
    wr_reg(`TCC_A_CMPB_HI, 32'h9A);
    @(negedge clk);
    chk("top_a held", 32'h1234, top_a);
    rd_reg(`TCC_A_CMPA_HI);
    chk("cmp hi direct", 32'h56, rdat);
    rd_reg(`TCC_A_CMPA_LO);
    chk("cmp lo buffer", 32'h78, rdat);
    pulse_tick(16'h0100, 1'b1);
    @(negedge clk);
    chk("top_a loaded", 32'h5678, top_a);
    // Mode 8 reloads at BOTTOM only; high byte 9A still sits in the latch
    wr_reg(`TCC_A_CTRL, 32'h8 << `TCC_C_WGM);
    wr_reg(`TCC_A_CMPA_LO, 32'hBC);
    pulse_tick(16'hFFFF, 1'b1);
    @(negedge clk);
    chk("top_a not at top", 32'h5678, top_a);
    @(posedge clk);
    bottom <= 1'b1;
    pulse_tick(16'h0000, 1'b0);
    @(posedge clk);
    bottom <= 1'b0;
    @(negedge clk);
    chk("top_a at bottom", 32'h9ABC, top_a);
    $display("Test buffer done");
  endtask : t_buffer

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task wrap_up;
    $display("Counts: %0d checks, %0d mismatches", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    $display("Watchdog expired");
    wrap_up();
  end

  initial begin
    errors = 0;
    check_count = 0;
    {rst_n, psel, penable, pwrite, tick, top, bottom, cwr, ack_c, ack_a, ack_b} = '0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    cnt = 16'h0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_capture();
    t_source();
    t_filter();
    t_compare();
    t_force();
    t_buffer();
    wrap_up();
  end

endmodule : tcc_timer16_cc_bench
